// file: rtl/spi_host_port.sv
// Host end: serial master issuing single and burst register accesses
`timescale 1ns/1ps
module spi_host_port (
    input  wire logic        clk,
    input  wire logic        rst_n,
    spi_link_if.host         link,
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic        burst,
    input  wire logic [1:0]  page,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  nbytes,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [7:0]  wr_data,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output logic             busy,
    output logic             done
);
    localparam int HALF = spi_port_pkg::SCK_HALF_CYC;

    // All control state of the host
    typedef struct packed {
        logic [1:0]             sdo_s;    // Data out synchroniser
        spi_port_pkg::host_st_t state;    // Sequencer state
        logic [7:0]             div;      // Half period divider
        logic                   chip_select_active_high;      // Select line
        logic                   sck;      // Serial clock line
        logic                   sdi;      // Data line to device
        logic [15:0]            sh;       // Outgoing shift register
        logic [3:0]             bits;     // Header bits sent
        logic                   hdr_done; // Header finished
        logic [2:0]             dbit;     // Data bit index
        logic                   dir;      // Direction of frame
        logic [7:0]             left;     // Bytes still to move
        logic [7:0]             rx;       // Incoming byte
        logic                   rvld;     // Read byte pulse
        logic [7:0]             rdat;     // Read byte
        logic                   dn;       // Frame finished pulse
        logic                   bsy;      // Frame in progress
    } host_st_r_t;

    host_st_r_t  st_r;
    host_st_r_t  st_nxt;
    logic        pop;       // Take a byte from buffer
    logic        f_vld;     // Buffer has data
    logic [7:0]  f_dat;     // Buffer head
    logic        half_end;  // Half period elapsed

    // Write data buffer; an empty buffer stalls the serial clock
    stream_fifo #(.W(8), .D(spi_port_pkg::FIFO_DEPTH)) u_wbuf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (f_vld),
        .out_ready (pop),
        .out_data  (f_dat)
    );

    assign half_end = int'(st_r.div) == HALF - 1;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_nxt       = st_r;
        pop          = 1'b0;
        st_nxt.sdo_s = {st_r.sdo_s[0], link.serial_out_pin};
        st_nxt.rvld  = 1'b0;
        st_nxt.dn    = 1'b0;
        unique case (st_r.state)
            spi_port_pkg::H_IDLE: begin
                if (start) begin
                    st_nxt.chip_select_active_high      = 1'b1;
                    st_nxt.bsy      = 1'b1;
                    st_nxt.sh       = {write, page, addr, burst,
                                       spi_port_pkg::UNUSED_VAL};
                    st_nxt.sdi      = write;
                    st_nxt.dir      = write;
                    st_nxt.bits     = '0;
                    st_nxt.hdr_done = 1'b0;
                    st_nxt.div      = '0;
                    st_nxt.left     = (burst && nbytes != '0) ? nbytes : 8'h01;
                    st_nxt.state    = spi_port_pkg::H_LOW;
                end
            end
            spi_port_pkg::H_LOW: begin
                st_nxt.div = st_r.div + 8'h01;
                if (half_end) begin
                    st_nxt.div   = '0;
                    st_nxt.sck   = 1'b1;
                    st_nxt.state = spi_port_pkg::H_HIGH;
                    st_nxt.rx    = {st_r.rx[6:0], st_r.sdo_s[1]};
                end
            end
            spi_port_pkg::H_HIGH: begin
                st_nxt.div = st_r.div + 8'h01;
                if (half_end) begin
                    st_nxt.div   = '0;
                    st_nxt.sck   = 1'b0;
                    st_nxt.sh    = {st_r.sh[14:0], 1'b0};
                    st_nxt.sdi   = st_r.sh[14];
                    st_nxt.state = spi_port_pkg::H_LOW;
                    if (!st_r.hdr_done) begin
                        st_nxt.bits = st_r.bits + 4'h1;
                        if (st_r.bits == 4'hF) begin
                            st_nxt.hdr_done = 1'b1;
                            st_nxt.dbit     = '0;
                            st_nxt.state    = spi_port_pkg::H_LOAD;
                        end
                    end else begin
                        st_nxt.dbit = st_r.dbit + 3'h1;
                        if (st_r.dbit == 3'h7) begin
                            st_nxt.rvld  = !st_r.dir;
                            st_nxt.rdat  = st_r.rx;
                            st_nxt.left  = st_r.left - 8'h01;
                            // close only after a whole byte
                            st_nxt.state = (st_r.left == 8'h01)
                                         ? spi_port_pkg::H_TAIL
                                         : spi_port_pkg::H_LOAD;
                        end
                    end
                end
            end
            spi_port_pkg::H_LOAD: begin
                // Write waits for buffered data with clock held low
                if (st_r.dir == spi_port_pkg::DIR_WRITE) begin
                    if (f_vld) begin
                        pop          = 1'b1;
                        st_nxt.sh    = {f_dat, 8'h00};
                        st_nxt.sdi   = f_dat[7];
                        st_nxt.state = spi_port_pkg::H_LOW;
                    end
                end else begin
                    st_nxt.sdi   = 1'b0;
                    st_nxt.state = spi_port_pkg::H_LOW;
                end
            end
            spi_port_pkg::H_TAIL: begin
                st_nxt.sdi = 1'b0;
                st_nxt.div = st_r.div + 8'h01;
                if (half_end) begin
                    st_nxt.div   = '0;
                    st_nxt.chip_select_active_high   = 1'b0;
                    st_nxt.bsy   = 1'b0;
                    st_nxt.dn    = 1'b1;
                    st_nxt.state = spi_port_pkg::H_IDLE;
                end
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.select_pin       = st_r.chip_select_active_high;
    assign link.serial_clock_pin = st_r.sck;
    assign link.serial_in_pin    = st_r.sdi;
    assign rd_valid              = st_r.rvld;
    assign rd_data               = st_r.rdat;
    assign busy                  = st_r.bsy;
    assign done                  = st_r.dn;
endmodule

// file: rtl/spi_port_pkg.sv
// Shared constants and types for the paged serial register port
package spi_port_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int          HDR_BITS   = 16;     // Header length in bits
    localparam int          DATA_BITS  = 8;      // Data packet length
    localparam int          PAGE_W     = 2;      // Page field width
    localparam int          ADDR_W     = 8;      // Register address width
    localparam int          DIR_POS    = 15;     // Direction bit position
    localparam int          PAGE_LO    = 13;     // Page field low bit
    localparam int          ADDR_LO    = 5;      // Address field low bit
    localparam int          BURST_POS  = 4;      // Burst flag position
    localparam logic        DIR_READ   = 1'b0;   // Direction code for read
    localparam logic        DIR_WRITE  = 1'b1;   // Direction code for write
    localparam logic [3:0]  UNUSED_VAL = 4'h0;   // Filler in unused slots

    // ****************************************
    // Register space
    // ****************************************
    localparam int          PAGES_IMPL = 3;      // Pages backed by storage
    localparam logic [7:0]  UNIMPL_VAL = 8'hFF;  // Read value, missing page
    localparam logic [7:0]  REG_RST    = 8'h00;  // Register reset value

    // ****************************************
    // Timing and buffering
    // ****************************************
    localparam int          CLK_NS      = 10;    // System clock period
    localparam int          SCK_HALF_NS = 100;   // Host serial clock half period
    localparam int          SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          FIFO_DEPTH  = 16;    // Write data buffer depth

    // Host sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_LOW,
        H_HIGH,
        H_LOAD,
        H_TAIL
    } host_st_t;

endpackage

// file: rtl/spi_link_if.sv
// Four-wire link between host end and device end
`timescale 1ns/1ps
interface spi_link_if;
    logic select_pin;        // Chip select, active high
    logic serial_clock_pin;  // Serial clock from host
    logic serial_in_pin;     // Data host to device
    logic serial_out_o;      // Device data driver value
    logic serial_out_oe;     // Device data driver enable
    logic serial_out_pin;    // Resolved data line

    // Released line floats; modelled as weak high
    assign serial_out_pin = serial_out_oe ? serial_out_o : 1'b1;

    modport device (
        input  select_pin,
        input  serial_clock_pin,
        input  serial_in_pin,
        output serial_out_o,
        output serial_out_oe
    );

    modport host (
        output select_pin,
        output serial_clock_pin,
        output serial_in_pin,
        input  serial_out_pin
    );
endinterface

// file: rtl/stream_fifo.sv
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module stream_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    // Whole control state in one word
    typedef struct packed {
        logic [AW-1:0] wp;      // Write pointer
        logic [AW-1:0] rp;      // Read pointer
        logic [AW:0]   cnt;     // Fill level
        logic          in_rdy;  // Not full
        logic          out_vld; // Not empty
    } fifo_st_t;

    fifo_st_t     st_r;
    fifo_st_t     st_nxt;
    logic [W-1:0] mem [D];      // Storage
    logic         push;
    logic         pop;

    assign push      = in_valid && st_r.in_rdy;
    assign pop       = out_ready && st_r.out_vld;
    assign in_ready  = st_r.in_rdy;
    assign out_valid = st_r.out_vld;
    assign out_data  = mem[st_r.rp];

    // ****************************************
    // Pointer and flag update
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt     = st_r.cnt + {AW'(0), push} - {AW'(0), pop};
        // Flags registered so both ready and valid come from flops
        st_nxt.in_rdy  = st_nxt.cnt != (AW+1)'(D);
        st_nxt.out_vld = st_nxt.cnt != '0;
    end

    // State register, storage write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r        <= '0;
            st_r.in_rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule

// file: rtl/spi_device_port.sv
// Device end: serial slave giving access to paged byte registers
`timescale 1ns/1ps

module spi_device_port (
    input  wire logic    clk,
    input  wire logic    rst_n,
    spi_link_if.device   link,
    output logic         wr_stb,
    output logic [1:0]   wr_page,
    output logic [7:0]   wr_addr,
    output logic [7:0]   wr_data,
    output logic         busy
);
    // ****************************************
    // State
    // ****************************************

    // All control state of the port
    typedef struct packed {
        logic [2:0]  sce_s;    // Select synchroniser and history
        logic [2:0]  sck_s;    // Clock synchroniser and history
        logic [1:0]  sdi_s;    // Data in synchroniser
        logic [4:0]  cnt;      // Header bits taken
        logic [15:0] hdr;      // Header shift register
        logic        hdr_done; // Header complete
        logic [7:0]  addr;     // Current register address
        logic [7:0]  rx;       // Incoming data byte
        logic [7:0]  tx;       // Outgoing data byte
        logic [2:0]  dbit;     // Data bit index
        logic        halt;     // Single access finished
        logic        so;       // Output data value
        logic        oe;       // Output enable
        logic        wstb;     // Write pulse to user side
        logic [1:0]  wpage;    // Page of last write
        logic [7:0]  waddr;    // Address of last write
        logic [7:0]  wdata;    // Data of last write
        logic        bsy;      // Frame open
    } dev_st_t;

    localparam int MEM_N = spi_port_pkg::PAGES_IMPL * 256;

    dev_st_t     st_r;        // Registered state
    dev_st_t     st_nxt;      // Next state
    logic [7:0]  mem [MEM_N]; // Register storage

    // Combinational helpers
    logic        sel;         // Synchronised select
    logic        rise;        // Serial clock rising edge
    logic        fall;        // Serial clock falling edge
    logic        bit_in;      // Synchronised data in
    logic [15:0] hdr_new;     // Header with current bit
    logic        dir;         // Direction of open frame
    logic [1:0]  page;        // Page of open frame
    logic        burst;       // Burst flag of open frame
    logic [7:0]  byte_new;    // Data byte with current bit
    logic        we;          // Storage write enable
    logic [9:0]  widx;        // Storage write index

    // ****************************************
    // Storage read
    // ****************************************

    // Read one location, missing pages answer with the fixed value
    function automatic logic [7:0] reg_read(input logic [1:0] pg,
                                            input logic [7:0] ad);
        logic [7:0] v;
        v = spi_port_pkg::UNIMPL_VAL;
        if (int'(pg) < spi_port_pkg::PAGES_IMPL) begin
            v = mem[{pg, ad}];
        end
        return v;
    endfunction

    // Header field views
    assign dir      = st_r.hdr[spi_port_pkg::DIR_POS];
    assign page     = st_r.hdr[spi_port_pkg::PAGE_LO +: spi_port_pkg::PAGE_W];
    assign burst    = st_r.hdr[spi_port_pkg::BURST_POS];

    // Edge detection on the settled samples only
    assign sel      = st_r.sce_s[1];
    assign rise     = st_r.sck_s[1] && !st_r.sck_s[2];
    assign fall     = !st_r.sck_s[1] && st_r.sck_s[2];
    assign bit_in   = st_r.sdi_s[1];

    assign hdr_new  = {st_r.hdr[14:0], bit_in};
    assign byte_new = {st_r.rx[6:0], bit_in};

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_nxt       = st_r;
        we           = 1'b0;
        widx         = {page, st_r.addr};
        // Pin synchronisers, first stage read only by second
        st_nxt.sce_s = {st_r.sce_s[1:0], link.select_pin};
        st_nxt.sck_s = {st_r.sck_s[1:0], link.serial_clock_pin};
        st_nxt.sdi_s = {st_r.sdi_s[0], link.serial_in_pin};
        st_nxt.wstb  = 1'b0;

        if (!sel) begin
            st_nxt.cnt      = '0;
            st_nxt.hdr_done = 1'b0;
            st_nxt.dbit     = '0;
            st_nxt.halt     = 1'b0;
            st_nxt.oe       = 1'b0;
            st_nxt.so       = 1'b0;
            st_nxt.bsy      = 1'b0;
            // partial byte dropped here, never stored
        end else begin
            st_nxt.bsy = 1'b1;
            if (rise && !st_r.halt) begin
                if (!st_r.hdr_done) begin
                    st_nxt.hdr = hdr_new;
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (int'(st_r.cnt) == spi_port_pkg::HDR_BITS - 1) begin
                        st_nxt.hdr_done = 1'b1;
                        st_nxt.dbit     = '0;
                        st_nxt.addr     = hdr_new[spi_port_pkg::ADDR_LO +: 8];
                        st_nxt.tx = reg_read(
                            hdr_new[spi_port_pkg::PAGE_LO +: 2],
                            hdr_new[spi_port_pkg::ADDR_LO +: 8]);
                    end
                end else begin
                    st_nxt.rx   = byte_new;
                    st_nxt.dbit = st_r.dbit + 3'h1;
                    if (st_r.dbit == 3'h7) begin
                        if (dir == spi_port_pkg::DIR_WRITE) begin
                            we           = int'(page) < spi_port_pkg::PAGES_IMPL;
                            st_nxt.wstb  = 1'b1;
                            st_nxt.wpage = page;
                            st_nxt.waddr = st_r.addr;
                            st_nxt.wdata = byte_new;
                        end
                        // burst flag picks single or burst
                        if (burst) begin
                            st_nxt.addr = st_r.addr + 8'h01;
                            st_nxt.tx   = reg_read(page, st_r.addr + 8'h01);
                        end else begin
                            // single access stops after one byte
                            st_nxt.halt = 1'b1;
                        end
                    end
                end
            end

            if (fall) begin
                if (st_r.hdr_done && !st_r.halt
                    && dir == spi_port_pkg::DIR_READ) begin
                    st_nxt.oe = 1'b1;
                    st_nxt.so = st_r.tx[7];
                    st_nxt.tx = {st_r.tx[6:0], 1'b0};
                end else begin
                    st_nxt.oe = 1'b0;
                    st_nxt.so = 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Storage write; contents not cleared by reset, kept small
    always_ff @(posedge clk) begin
        if (we) begin
            mem[widx] <= byte_new;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.serial_out_o  = st_r.so;
    assign link.serial_out_oe = st_r.oe;
    assign wr_stb             = st_r.wstb;
    assign wr_page            = st_r.wpage;
    assign wr_addr            = st_r.waddr;
    assign wr_data            = st_r.wdata;
    assign busy               = st_r.bsy;
endmodule

// file: tb/spi_link_properties.sv
// Link protocol checker for the paged serial register port
`timescale 1ns/1ps
module spi_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic select_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    logic        sck_q;   // Clock level one cycle ago
    logic [11:0] rise_r;  // Clock rises seen in this frame
    logic        dir_r;   // First header bit of the frame
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Frame bookkeeping; rise count cleared between frames, first bit kept until next frame's first rise
    always_ff @(posedge clk) begin
        sck_q <= serial_clock_pin;
        if (!rst_n || !select_pin) begin
            rise_r <= 12'h000;
        end else if (serial_clock_pin && !sck_q) begin
            rise_r <= rise_r + 12'h001;
        end
        if (!rst_n) begin
            dir_r <= 1'b1;
        end else if (serial_clock_pin && !sck_q && rise_r == 12'h000) begin
            dir_r <= serial_in_pin;
        end
    end
    AST_SEL_BYTE: assert property (
        $fell(select_pin) |-> rise_r >= 12'h010 && rise_r[2:0] == 3'h0)
        else $error("select dropped off a byte boundary");
    AST_OE_AFTER_HDR: assert property ($rose(serial_out_oe) |-> rise_r >= 12'h010 && !dir_r)
        else $error("data out driven outside read data");
    AST_OE_DROP: assert property ($fell(select_pin) |-> ##[0:5] !serial_out_oe)
        else $error("data out not released after select low");
    AST_SCK_IDLE: assert property (!select_pin |-> !serial_clock_pin)
        else $error("serial clock active outside a frame");
    AST_SCK_HIGH: assert property ($rose(serial_clock_pin) |-> serial_clock_pin[*8])
        else $error("serial clock high phase too short");
    AST_SCK_LOW: assert property ($fell(serial_clock_pin) |-> !serial_clock_pin[*8])
        else $error("serial clock low phase too short");
    AST_SDI_HOLD: assert property (serial_clock_pin && sck_q |-> $stable(serial_in_pin))
        else $error("data in moved while clock high");
    AST_SDO_HOLD: assert property (
        serial_out_oe && serial_clock_pin && sck_q |-> $stable(serial_out_o))
        else $error("data out moved while clock high");
    cover property ($rose(serial_out_oe));
    cover property ($fell(select_pin) && rise_r > 12'h018);
    cover property ($fell(select_pin) && dir_r);
endmodule

// file: tb/pmic_spi_register_port_bench.sv
// Bench joining host end and device end of the serial register port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module pmic_spi_register_port_bench;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, write = 1'b0, burst = 1'b0, wr_valid = 1'b0;
    logic [1:0]  page = 2'h0;
    logic [7:0]  addr = 8'h00, nbytes = 8'h00, wr_data = 8'h00, rd_data, d_addr, d_data;
    logic [1:0]  d_page;
    logic        wr_ready, rd_valid, busy, done, wr_stb, d_busy;
    logic [17:0] wq[$];        // Committed device writes
    logic [7:0]  rq[$];        // Bytes the host read back
    int          n_mismatch = 0;
    int          tests_run = 0;
    spi_link_if link ();
    spi_device_port i_spi_device_port (.clk(clk), .rst_n(rst_n), .link(link.device),
        .wr_stb(wr_stb), .wr_page(d_page), .wr_addr(d_addr), .wr_data(d_data), .busy(d_busy));
    spi_host_port i_spi_host_port (.clk(clk), .rst_n(rst_n), .link(link.host), .start(start),
        .write(write), .burst(burst), .page(page), .addr(addr), .nbytes(nbytes),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_data(rd_data), .busy(busy), .done(done));
    spi_link_properties i_spi_link_properties (.clk(clk), .rst_n(rst_n),
        .select_pin(link.select_pin), .serial_clock_pin(link.serial_clock_pin),
        .serial_in_pin(link.serial_in_pin), .serial_out_o(link.serial_out_o),
        .serial_out_oe(link.serial_out_oe));
    always #5 clk = ~clk;
    // Collect both user sides
    always @(posedge clk) begin
        if (wr_stb === 1'b1) wq.push_back({d_page, d_addr, d_data});
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    // Queue n write bytes; checks the buffer refuses once full
    task automatic fill(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            wr_valid = 1'b1;
            wr_data = b + 8'(i);
            @(posedge clk) #1;
        end
        wr_valid = 1'b0;
        if (n == 16) `CHK("fifo_full", 1'b0, wr_ready)
    endtask
    // One host access, bounded wait for completion
    task automatic xfer(input logic w, b, input logic [1:0] p, input logic [7:0] a, n);
        int k = 0;
        wq.delete();
        rq.delete();
        {write, burst, page, addr, nbytes, start} = {w, b, p, a, n, 1'b1};
        @(posedge clk) #1;
        start = 1'b0;
        `CHK("host_busy", 1'b1, busy)
        while (done !== 1'b1 && k < 20000) begin
            @(posedge clk) #1;
            k++;
        end
        `CHK("done", 1'b1, done)
        `CHK("host_idle", 1'b0, busy)
        `CHK("dev_busy", 1'b1, d_busy)
        repeat (6) @(posedge clk) #1;
        `CHK("dev_idle", 1'b0, d_busy)
    endtask
    // Single write then read back, exactly one location
    task automatic t_single();
        fill(8'hA5, 1);
        xfer(1'b1, 1'b0, 2'h0, 8'h10, 8'h01);
        `CHK("single_wr_count", 1, wq.size())
        `CHK("single_wr", {2'h0, 8'h10, 8'hA5}, wq[0])
        xfer(1'b0, 1'b0, 2'h0, 8'h10, 8'h01);
        `CHK("single_rd", 8'hA5, rq[0])
        `CHK("single_rd_count", 1, rq.size())
    endtask
    // Full buffer burst across the address wrap, then burst read
    task automatic t_burst();
        fill(8'h30, 16);
        xfer(1'b1, 1'b1, 2'h1, 8'hF8, 8'h10);
        `CHK("burst_wr_count", 16, wq.size())
        for (int i = 0; i < 16; i++)
            `CHK("burst_wr", {2'h1, 8'hF8 + 8'(i), 8'h30 + 8'(i)}, wq[i])
        // Fifteen bytes, so the look-ahead fetch stays on written storage
        xfer(1'b0, 1'b1, 2'h1, 8'hF8, 8'h0F);
        `CHK("burst_rd_count", 15, rq.size())
        for (int i = 0; i < 15; i++) `CHK("burst_rd", 8'h30 + 8'(i), rq[i])
    endtask
    // Page without storage reads all ones
    task automatic t_unimpl();
        xfer(1'b0, 1'b0, 2'h3, 8'h44, 8'h01);
        `CHK("unimpl_rd", 8'hFF, rq[0])
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk) #1;
        `CHK("idle_release", 1'b0, link.serial_out_oe)
        t_single();
        t_burst();
        t_unimpl();
        summarize();
    end
    // Watchdog against a hung frame
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
endmodule
